// [hdl/bsfeu_core.sv]
module bsfeu_core
    import bsfeu_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       op_valid,
    input  wire logic [5:0] op_code,
    input  wire logic [7:0] reg_in,
    input  wire logic [2:0] bit_sel,
    input  wire logic [4:0] io_addr,
    input  wire logic [7:0] io_rdata,
    output logic            op_ready,
    output logic            reg_we,
    output logic      [7:0] reg_out,
    output logic            io_we,
    output logic      [4:0] io_waddr,
    output logic      [7:0] io_wdata,
    output logic      [7:0] status_flag_register,
    output logic            sleep_req,
    output logic            wdog_restart,
    output logic            debug_break
);
    // ==========================================
    // decode and shifter
    bsfeu_op_type    op;
    bsfeu_state_type state_q;
    logic [7:0]      shift_res;
    logic            shift_c;
    logic            shift_flags;
    logic            take;

    assign op   = bsfeu_op_type'(op_code);
    assign take = op_valid && (state_q == ST_READY);

    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction : bit_mask

    bsfeu_shifter u_shift (
        .op          (op),
        .operand     (reg_in),
        .carry_in    (status_flag_register[FLAG_C]),
        .result      (shift_res),
        .carry_out   (shift_c),
        .flags_valid (shift_flags)
    );

    // ==========================================
    // sequencing: io clear holds a second cycle for the write-back
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q  <= ST_READY;
            op_ready <= 1'b1;
        end else begin
            case (state_q)
                ST_READY: begin
                    if (take && op == clear_io_bit_op) begin
                        state_q  <= ST_IO_WRITE; // RQ1
                        op_ready <= 1'b0;
                    end
                end
                default: begin
                    state_q  <= ST_READY;
                    op_ready <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================
    // io write port; read data taken in the first cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            io_we    <= 1'b0;
            io_waddr <= 5'h00;
            io_wdata <= 8'h00;
        end else begin
            io_we <= 1'b0;
            if (take && op == clear_io_bit_op) begin
                io_we    <= 1'b1; // RQ1
                io_waddr <= io_addr;
                io_wdata <= io_rdata & ~bit_mask(bit_sel);
            end
        end
    end

    // ==========================================
    // register write-back
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_we  <= 1'b0;
            reg_out <= 8'h00;
        end else begin
            reg_we <= 1'b0;
            if (take) begin
                if (shift_flags) begin
                    reg_we  <= 1'b1;
                    reg_out <= shift_res;
                end else if (op == nibble_swap_op) begin
                    reg_we  <= 1'b1;
                    reg_out <= {reg_in[3:0], reg_in[7:4]}; // RQ16
                end else if (op == transfer_flag_to_bit_op) begin
                    reg_we  <= 1'b1;
                    reg_out <= status_flag_register[FLAG_T] ? // RQ8
                               (reg_in | bit_mask(bit_sel)) :
                               (reg_in & ~bit_mask(bit_sel));
                end
            end
        end
    end

    // ==========================================
    // status flags; every op not listed leaves them alone
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_flag_register <= STATUS_RESET;
        end else if (take) begin
            if (shift_flags) begin
                // V = N xor C after shift, S = N xor V
                status_flag_register[FLAG_C] <= shift_c; // RQ2 RQ3 RQ4 RQ5 RQ6
                status_flag_register[FLAG_Z] <= (shift_res == DATA_ZERO);
                status_flag_register[FLAG_N] <= shift_res[7];
                status_flag_register[FLAG_V] <= shift_res[7] ^ shift_c;
                status_flag_register[FLAG_S] <= shift_c;
            end else begin
                case (op)
                    indexed_flag_set_op:     status_flag_register[bit_sel] <= 1'b1; // RQ15
                    indexed_flag_clear_op:   status_flag_register[bit_sel] <= 1'b0; // RQ15
                    bit_to_transfer_flag_op: status_flag_register[FLAG_T] <= reg_in[bit_sel]; // RQ7
                    carry_set_op:            status_flag_register[FLAG_C] <= 1'b1; // RQ15
                    carry_clear_op:          status_flag_register[FLAG_C] <= 1'b0; // RQ15
                    negative_set_op:         status_flag_register[FLAG_N] <= 1'b1; // RQ15
                    negative_clear_op:       status_flag_register[FLAG_N] <= 1'b0; // RQ15
                    zero_set_op:             status_flag_register[FLAG_Z] <= 1'b1; // RQ15
                    zero_clear_op:           status_flag_register[FLAG_Z] <= 1'b0; // RQ15
                    global_irq_enable_op:    status_flag_register[FLAG_I] <= 1'b1; // RQ15
                    global_irq_disable_op:   status_flag_register[FLAG_I] <= 1'b0; // RQ15
                    signed_flag_set_op:      status_flag_register[FLAG_S] <= 1'b1; // RQ11
                    signed_flag_clear_op:    status_flag_register[FLAG_S] <= 1'b0; // RQ11
                    overflow_set_op:         status_flag_register[FLAG_V] <= 1'b1; // RQ9
                    overflow_clear_op:       status_flag_register[FLAG_V] <= 1'b0; // RQ9
                    transfer_flag_set_op:    status_flag_register[FLAG_T] <= 1'b1; // RQ15
                    transfer_flag_clear_op:  status_flag_register[FLAG_T] <= 1'b0; // RQ15
                    half_carry_set_op:       status_flag_register[FLAG_H] <= 1'b1; // RQ10
                    half_carry_clear_op:     status_flag_register[FLAG_H] <= 1'b0; // RQ10
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================
    // control pulses to sleep, watchdog and debug logic
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sleep_req    <= 1'b0;
            wdog_restart <= 1'b0;
            debug_break  <= 1'b0;
        end else begin
            sleep_req    <= take && (op == sleep_op); // RQ12
            wdog_restart <= take && (op == watchdog_restart_op); // RQ13
            debug_break  <= take && (op == debug_break_op); // RQ14
        end
    end
endmodule : bsfeu_core

// [hdl/bsfeu_pkg.sv]
// Functional notes
// (RQ1) clear_io_bit_op zeroes selected io bit, flags untouched, two cycles
// (RQ2) logical_left_shift_op: bit n to n+1, zero into bit 0, updates Z C N V
// (RQ3) logical_right_shift_op: bit n+1 to n, zero into bit 7, Z C N V, one cycle
// (RQ4) rotate_left_carry_op: carry into bit 0, bit 7 to carry, Z C N V, one cycle
// (RQ5) rotate_right_carry_op: carry into bit 7, bit 0 to carry, Z C N V, one cycle
// (RQ6) arith_right_shift_op keeps sign bit, shifts rest right, Z C N V, one cycle
// (RQ7) bit_to_transfer_flag_op copies selected source bit into T only
// (RQ8) transfer_flag_to_bit_op copies T into selected bit, no flag change
// (RQ9) overflow set and clear ops touch only V, one cycle
// (RQ10) half carry set and clear ops touch only H, one cycle
// (RQ11) signed flag set and clear ops touch only S, one cycle
// (RQ12) sleep: one cycle, no flags, pulses request to sleep logic
// (RQ13) watchdog_restart_op: one cycle, no flags, pulses watchdog restart
// (RQ14) break: debug only, pulses debug request, no flag change
// (RQ15) single flag ops for C N Z T I, indexed set and clear by 3-bit index
// (RQ16) nibble swap one cycle no flags; idle_op alters nothing
package bsfeu_pkg;
    // ==========================================
    // status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] IO_CLEAR_CYCLES = 2'h2;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // ==========================================
    // operation codes
    typedef enum logic [5:0] {
        idle_op                 = 6'h00,
        clear_io_bit_op         = 6'h01,
        logical_left_shift_op   = 6'h02,
        logical_right_shift_op  = 6'h03,
        rotate_left_carry_op    = 6'h04,
        rotate_right_carry_op   = 6'h05,
        arith_right_shift_op    = 6'h06,
        nibble_swap_op          = 6'h07,
        indexed_flag_set_op     = 6'h08,
        indexed_flag_clear_op   = 6'h09,
        bit_to_transfer_flag_op = 6'h0a,
        transfer_flag_to_bit_op = 6'h0b,
        carry_set_op            = 6'h0c,
        carry_clear_op          = 6'h0d,
        negative_set_op         = 6'h0e,
        negative_clear_op       = 6'h0f,
        zero_set_op             = 6'h10,
        zero_clear_op           = 6'h11,
        global_irq_enable_op    = 6'h12,
        global_irq_disable_op   = 6'h13,
        signed_flag_set_op      = 6'h14,
        signed_flag_clear_op    = 6'h15,
        overflow_set_op         = 6'h16,
        overflow_clear_op       = 6'h17,
        transfer_flag_set_op    = 6'h18,
        transfer_flag_clear_op  = 6'h19,
        half_carry_set_op       = 6'h1a,
        half_carry_clear_op     = 6'h1b,
        sleep_op                = 6'h1c,
        watchdog_restart_op     = 6'h1d,
        debug_break_op          = 6'h1e
    } bsfeu_op_type;

    typedef enum logic [1:0] {
        ST_READY    = 2'b00,
        ST_IO_WRITE = 2'b01
    } bsfeu_state_type;
endpackage : bsfeu_pkg

// [hdl/bsfeu_shifter.sv]
module bsfeu_shifter
    import bsfeu_pkg::*;
(
    input  bsfeu_op_type    op,
    input  wire logic [7:0] operand,
    input  wire logic       carry_in,
    output logic      [7:0] result,
    output logic            carry_out,
    output logic            flags_valid
);
    // ==========================================
    // combinational shift network
    always_comb begin
        result      = operand;
        carry_out   = carry_in;
        flags_valid = 1'b1;
        case (op)
            logical_left_shift_op: begin
                result    = {operand[6:0], 1'b0}; // RQ2
                carry_out = operand[7];
            end
            logical_right_shift_op: begin
                result    = {1'b0, operand[7:1]}; // RQ3
                carry_out = operand[0];
            end
            rotate_left_carry_op: begin
                result    = {operand[6:0], carry_in}; // RQ4
                carry_out = operand[7];
            end
            rotate_right_carry_op: begin
                result    = {carry_in, operand[7:1]}; // RQ5
                carry_out = operand[0];
            end
            arith_right_shift_op: begin
                result    = {operand[7], operand[7:1]}; // RQ6
                carry_out = operand[0];
            end
            default: begin
                flags_valid = 1'b0;
            end
        endcase
    end
endmodule : bsfeu_shifter

// [testbench/bsfeu_chk.sv]
module bsfeu_chk
    import bsfeu_pkg::*;
(
    input logic       core_clk,
    input logic       nrst,
    input logic       op_valid,
    input logic [5:0] op_code,
    input logic [7:0] reg_in,
    input logic [2:0] bit_sel,
    input logic [7:0] io_rdata,
    input logic       op_ready,
    input logic [7:0] reg_out,
    input logic [7:0] io_wdata,
    input logic [7:0] status_flag_register
);
    // ==========================================
    // results land one cycle after the taking edge
    wire       acc = op_valid && op_ready;
    wire [7:0] sf  = status_flag_register;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    property p_io;
        acc && op_code == clear_io_bit_op |=> !op_ready && $stable(sf)
            && io_wdata == ($past(io_rdata) & ~(8'h01 << $past(bit_sel))) ##1 op_ready;
    endproperty
    a_io: assert property (p_io) else $error("io bit clear wrong");
    property p_lsl;
        acc && op_code == logical_left_shift_op |=> reg_out == $past(reg_in) << 1;
    endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong");
    property p_lsr;
        acc && op_code == logical_right_shift_op |=> reg_out == $past(reg_in) >> 1
            && sf[3:0] == {$past(reg_in[0]), 1'b0, reg_out == 8'h00, $past(reg_in[0])};
    endproperty
    a_lsr: assert property (p_lsr) else $error("right shift wrong");
    property p_rol;
        acc && op_code == rotate_left_carry_op |=> sf[FLAG_C] == $past(reg_in[7])
            && reg_out == ($past(reg_in) << 1 | $past(sf) & 8'h01);
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left wrong");
    property p_ror;
        acc && op_code == rotate_right_carry_op |=> sf[FLAG_C] == $past(reg_in[0])
            && reg_out == ($past(reg_in) >> 1 | $past(sf) << 7);
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right wrong");
    property p_asr;
        acc && op_code == arith_right_shift_op
            |=> reg_out == ($past(reg_in) >> 1 | $past(reg_in) & 8'h80);
    endproperty
    a_asr: assert property (p_asr) else $error("arith shift wrong");
    property p_ovf;
        acc && op_code == overflow_set_op |=> sf == ($past(sf) | 8'h08);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow set wrong");
    property p_hcc;
        acc && op_code == half_carry_clear_op |=> sf == ($past(sf) & 8'hdf);
    endproperty
    a_hcc: assert property (p_hcc) else $error("half carry clear wrong");
    c_io: cover property (acc && op_code == clear_io_bit_op);
    c_refused: cover property (op_valid && !op_ready);
    c_asr: cover property (acc && op_code == arith_right_shift_op);
endmodule : bsfeu_chk

bind bsfeu_core bsfeu_chk u_chk (.*);

// [testbench/bsfeu_tb_top.sv]
module bsfeu_tb_top
    import bsfeu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // stimulus with a reference flag image
    logic       core_clk = 1'b0, nrst = 1'b0, op_valid = 1'b0, op_ready, reg_we, io_we;
    logic       sleep_req, wdog_restart, debug_break;
    logic [5:0] op_code = 6'h00;
    logic [7:0] reg_in = 8'h00, io_rdata = 8'h00, sf = 8'h00, reg_out, io_wdata;
    logic [7:0] status_flag_register;
    logic [2:0] bit_sel = 3'h0;
    logic [4:0] io_addr = 5'h00, io_waddr;
    int         mismatches = 0, n_compared = 0;
    // flag touched by each dedicated set/clear pair, in opcode order
    localparam logic [2:0] FB [8] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6, 3'h5};
    localparam logic [7:0] SV [4] = '{8'h81, 8'h80, 8'h01, 8'h00};
    bsfeu_core DUT (.*);
    always #5 core_clk = ~core_clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        chk(16'(got), 16'(exp));
    endtask : chk_data
    task automatic chk_flags(input logic [7:0] got, input logic [7:0] exp);
        chk(16'(got), 16'(exp));
    endtask : chk_flags
    task automatic tally_and_finish();
        $display("mismatches %0d n_compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic exec(input bsfeu_op_type op, input logic [7:0] r, input logic [2:0] b);
        logic [7:0] er;
        logic [5:0] gctl, ectl;
        logic c;
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= op;
        reg_in <= r;
        bit_sel <= b;
        @(posedge core_clk);
        op_valid <= 1'b0;
        #1;
        case (op)
            logical_left_shift_op: {c, er} = {r, 1'b0};
            logical_right_shift_op: {er, c} = {1'b0, r};
            rotate_left_carry_op: {c, er} = {r, sf[FLAG_C]};
            rotate_right_carry_op: {er, c} = {sf[FLAG_C], r};
            arith_right_shift_op: {er, c} = {r[7], r};
            nibble_swap_op: er = {r[3:0], r[7:4]};
            transfer_flag_to_bit_op: er = r & ~(8'h01 << b) | {7'h00, sf[FLAG_T]} << b;
            bit_to_transfer_flag_op: sf[FLAG_T] = r[b];
            indexed_flag_set_op, indexed_flag_clear_op: sf[b] = ~op[0];
            default: if (op inside {[carry_set_op:half_carry_clear_op]})
                sf[FB[op[4:1] - 4'h6]] = ~op[0];
        endcase
        // shift flags: v = n ^ c, s = n ^ v
        if (op inside {[logical_left_shift_op:arith_right_shift_op]})
            sf[4:0] = {c, er[7] ^ c, er[7], er == 8'h00, c};
        gctl = {op_ready, io_we, reg_we, sleep_req, wdog_restart, debug_break};
        ectl = {2'b10, op inside {[logical_left_shift_op:nibble_swap_op], transfer_flag_to_bit_op},
                op == sleep_op, op == watchdog_restart_op, op == debug_break_op};
        chk(16'(gctl), 16'(ectl));
        if (reg_we === 1'b1) chk_data(reg_out, er);
        chk_flags(status_flag_register, sf);
    endtask : exec
    task automatic t_ops();
        foreach (SV[i]) for (int o = 2; o < 7; o++) exec(bsfeu_op_type'(o), SV[i], 3'h0);
        for (int o = 12; o < 28; o += 2) exec(bsfeu_op_type'(o), 8'h00, 3'h0);
        for (int o = 13; o < 28; o += 2) exec(bsfeu_op_type'(o), 8'h00, 3'h0);
        for (int i = 0; i < 16; i++) exec(bsfeu_op_type'(8 + i[3]), 8'h00, 3'(i));
        for (int i = 0; i < 8; i++) begin
            exec(bit_to_transfer_flag_op, 8'h5a, 3'(i));
            exec(transfer_flag_to_bit_op, 8'hc3, 3'(7 - i));
        end
        exec(nibble_swap_op, 8'h1e, 3'h0);
        for (int o = 28; o < 31; o++) exec(bsfeu_op_type'(o), 8'hff, 3'h0);
        exec(idle_op, 8'hff, 3'h0);
    endtask : t_ops
    task automatic t_io();
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= clear_io_bit_op;
        io_addr <= 5'h15;
        io_rdata <= 8'hff;
        bit_sel <= 3'h7;
        @(posedge core_clk);
        // offered while busy, must be dropped
        op_code <= logical_left_shift_op;
        reg_in <= 8'h81;
        #1;
        chk(16'({op_ready, io_we, io_waddr, io_wdata}), 16'({2'b01, 5'h15, 8'h7f}));
        @(posedge core_clk);
        op_code <= clear_io_bit_op;
        io_rdata <= 8'h01;
        bit_sel <= 3'h0;
        #1;
        chk(16'({op_ready, io_we, reg_we, status_flag_register}), 16'({3'b100, sf}));
        @(posedge core_clk);
        op_valid <= 1'b0;
        #1;
        chk(16'({op_ready, io_we, io_wdata}), 16'({2'b01, 8'h00}));
    endtask : t_io
    task automatic t_reset();
        // leave flags, result and io address nonzero so the reset values mean something
        exec(global_irq_enable_op, 8'h00, 3'h0);
        exec(logical_left_shift_op, 8'hc1, 3'h0);
        @(posedge core_clk);
        nrst <= 1'b0;
        sf = STATUS_RESET;
        #1;
        chk(16'({op_ready, reg_we, io_we, sleep_req, wdog_restart, debug_break, io_waddr}),
            16'({6'b100000, 5'h00}));
        chk_data(reg_out, 8'h00);
        chk_data(io_wdata, 8'h00);
        chk_flags(status_flag_register, sf);
        @(posedge core_clk);
        nrst <= 1'b1;
        exec(carry_set_op, 8'h00, 3'h0);
    endtask : t_reset
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        t_ops();
        t_io();
        t_reset();
        // let the checker finish its last attempts before the verdict
        repeat (2) @(posedge core_clk);
        tally_and_finish();
    end
endmodule : bsfeu_tb_top
